// File: xda_xdata_decoder.sv
// External-data decoder: auxiliary RAM, nonvolatile array with page writes, pass-through.
// Notes on behaviour
// - Enabled aux RAM serves 0000H to 01FFH
// - Ports hold old values on aux accesses
// - Page select supplies upper byte for pointers
// - Other moves run on the external bus
// - Aux RAM enable clears at reset
// - Nv enable maps array at FF80H-FFFFH
// - Page value 02H decodes as nv region
// - Write self-times; busy in page bit 7
// - Two 64-byte pages; one program cycle
// - Bytes within 150us keep page load
// - 300us silence starts the programming cycle
// - Address bit 6 picks page; same page
// - Bytes load at any offset, any order
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module xda_xdata_decoder #(
   parameter int LOAD_WIN = xda_pkg::LOAD_WINDOW_CYC, // Cycles of the byte-load window
   parameter int LOAD_END = xda_pkg::LOAD_END_CYC,    // Cycles of silence ending load
   parameter int PROG_LEN = xda_pkg::PROG_CYC         // Cycles of one programming cycle
) (
   input  wire logic        mclk_i,
   input  wire logic        reset_n_i,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq_o,
   // Core external-data move port
   input  wire logic        xmov_req_i,
   input  wire logic        xmov_we_i,
   input  wire logic        xmov_ptr8_i,
   input  wire logic [15:0] xmov_addr_i,
   input  wire logic [7:0]  xmov_wdata_i,
   output logic             xmov_ack_o,
   output logic      [7:0]  xmov_rdata_o,
   // Standard multiplexed external cycle engine
   output logic             ext_req_o,
   output logic             ext_we_o,
   output logic      [15:0] ext_addr_o,
   output logic      [7:0]  ext_wdata_o,
   input  wire logic        ext_ack_i,
   input  wire logic [7:0]  ext_rdata_i,
   output logic      [7:0]  muxed_addr_data_port_o,
   output logic      [7:0]  high_addr_port_o
);
   import xda_pkg::*;

   logic [7:0]       ctrl;                  // Chip control
   logic [6:0]       page_sel;              // Writable part of xdata_page_select_reg
   logic [EV_W-1:0]  ev_stat;               // Sticky events
   logic [EV_W-1:0]  ev_mask;               // Event enables
   logic             wprot;                 // Write protection state
   logic [1:0]       key_stage;             // Progress through the unlock key
   logic [7:0]       aux_mem [512];         // Auxiliary RAM
   logic [7:0]       nv_mem  [128];         // Nonvolatile array
   logic [7:0]       pg_buf  [64];          // Page-load buffer
   logic [63:0]      pg_mask;               // Which buffer bytes were loaded
   logic             pg_sel;                // Page latched for the running load
   logic [31:0]      nv_cnt;                // Load or programming timer
   xda_nvstate_t     nv_state;
   xda_xstate_t      x_state;
   logic             aux_enable;            // Alias of control bit, aux_ram_enable
   logic             nv_array_enable;
   logic             nv_busy;
   logic [15:0]      eff_addr;              // Full address after page substitution
   logic             hit_aux;
   logic             hit_nv;
   logic             x_take;                // New move accepted this cycle
   logic             nv_wr;                 // Nonvolatile write attempt this cycle
   logic [6:0]       nv_ofs;
   logic             key_hit;               // Write consumed by the key sequence
   logic             load_ok;               // Write goes into the page buffer
   logic             prog_end;              // Programming cycle completes
   logic             wb_hit;                // Bus access at the ack edge
   logic             wb_wr;

   assign aux_enable      = ctrl[AUX_EN_BIT];
   assign nv_array_enable = ctrl[NV_EN_BIT];
   assign nv_busy         = (nv_state == NS_PROG);

   // Pointer moves take the upper byte from page select, except the nv page
   always_comb begin
      if (xmov_ptr8_i) begin
         if ({1'b0, page_sel} == PAGE_NV) begin
            eff_addr = {NV_FIRST[15:7], xmov_addr_i[6:0]};
         end else begin
            eff_addr = {1'b0, page_sel, xmov_addr_i[7:0]};
         end
      end else begin
         eff_addr = xmov_addr_i;
      end
   end

   // Decode; anything not claimed on chip falls through to the external bus
   assign hit_aux = aux_enable && (eff_addr <= AUX_LAST);
   assign hit_nv  = nv_array_enable && (eff_addr >= NV_FIRST);
   assign x_take  = (x_state == XS_IDLE) && xmov_req_i;
   assign nv_wr   = x_take && hit_nv && !hit_aux && xmov_we_i;
   assign nv_ofs  = eff_addr[6:0];

   // Key writes are swallowed so that stray data cannot half-open the lock
   always_comb begin
      unique case (key_stage)
         2'd0:    key_hit = (nv_ofs == KEY_OFS_A) && (xmov_wdata_i == KEY_DAT_A);
         2'd1:    key_hit = (nv_ofs == KEY_OFS_B) && (xmov_wdata_i == KEY_DAT_B);
         2'd2:    key_hit = (nv_ofs == KEY_OFS_A) &&
                            ((xmov_wdata_i == KEY_CMD_ON) || (xmov_wdata_i == KEY_CMD_OFF));
         default: key_hit = 1'b0;
      endcase
   end

   // Loads land only when not busy, unprotected, same page and in time
   always_comb begin
      load_ok = 1'b0;
      if (nv_wr && !key_hit && !wprot) begin
         unique case (nv_state)
            NS_IDLE: load_ok = 1'b1;
            NS_LOAD: load_ok = (nv_ofs[NV_PAGE_BIT] == pg_sel) && (nv_cnt < LOAD_WIN);
            NS_PROG: load_ok = 1'b0;
         endcase
      end
   end

   assign prog_end = (nv_state == NS_PROG) && (nv_cnt == 32'(PROG_LEN - 1));

   // Key sequence tracker and protection state
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         key_stage <= 2'd0;
         wprot     <= 1'b0;
      end else if (nv_wr) begin
         if (!key_hit) begin
            key_stage <= 2'd0;                                                      // Broken key restarts
         end else if (key_stage == 2'd2) begin
            key_stage <= 2'd0;
            wprot     <= (xmov_wdata_i == KEY_CMD_ON);
         end else begin
            key_stage <= key_stage + 2'd1;
         end
      end
   end

   // Page load and self-timed programming
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         nv_state <= NS_IDLE;
         nv_cnt   <= 32'h0000_0000;
         pg_sel   <= 1'b0;
         pg_mask  <= 64'h0;
      end else begin
         unique case (nv_state)
            NS_IDLE: begin
               if (load_ok) begin
                  nv_state <= NS_LOAD;
                  nv_cnt   <= 32'h0000_0000;
                  pg_sel   <= nv_ofs[NV_PAGE_BIT];
                  pg_mask  <= 64'h1 << nv_ofs[5:0];
               end
            end
            NS_LOAD: begin
               if (load_ok) begin
                  nv_cnt  <= 32'h0000_0000;
                  pg_mask <= pg_mask | (64'h1 << nv_ofs[5:0]);
               end else if (nv_cnt == 32'(LOAD_END - 1)) begin
                  nv_state <= NS_PROG;
                  nv_cnt   <= 32'h0000_0000;
               end else begin
                  nv_cnt <= nv_cnt + 32'h1;
               end
            end
            NS_PROG: begin
               if (prog_end) begin
                  nv_state <= NS_IDLE;
                  pg_mask  <= 64'h0;
               end else begin
                  nv_cnt <= nv_cnt + 32'h1;
               end
            end
         endcase
      end
   end

   // Buffer fill; any offset, any order
   always_ff @(posedge mclk_i) begin
      if (load_ok) begin
         pg_buf[nv_ofs[5:0]] <= xmov_wdata_i;
      end
   end

   // Array update; all loaded bytes commit together at cycle end
   generate
      for (genvar i = 0; i < 128; i++) begin : g_nv
         always_ff @(posedge mclk_i) begin
            if (prog_end && (pg_sel == 1'(i / 64)) && pg_mask[i % 64]) begin
               nv_mem[i] <= pg_buf[i % 64];
            end
         end
      end
   endgenerate

   // Auxiliary RAM write
   always_ff @(posedge mclk_i) begin
      if (x_take && hit_aux && xmov_we_i) begin
         aux_mem[eff_addr[8:0]] <= xmov_wdata_i;
      end
   end

   // Core move sequencer; on-chip moves answer the cycle after the request
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         x_state      <= XS_IDLE;
         xmov_ack_o   <= 1'b0;
         xmov_rdata_o <= 8'h00;
         ext_req_o    <= 1'b0;
         ext_we_o     <= 1'b0;
         ext_addr_o   <= 16'h0000;
         ext_wdata_o  <= 8'h00;
      end else begin
         xmov_ack_o <= 1'b0;
         unique case (x_state)
            XS_IDLE: begin
               if (xmov_req_i) begin
                  if (hit_aux) begin
                     xmov_ack_o   <= 1'b1;
                     xmov_rdata_o <= aux_mem[eff_addr[8:0]];
                     x_state      <= XS_DONE;
                  end else if (hit_nv) begin
                     xmov_ack_o   <= 1'b1;
                     xmov_rdata_o <= nv_mem[nv_ofs];
                     x_state      <= XS_DONE;
                  end else begin
                     ext_req_o   <= 1'b1;
                     ext_we_o    <= xmov_we_i;
                     ext_addr_o  <= eff_addr;
                     ext_wdata_o <= xmov_wdata_i;
                     x_state     <= XS_EXT;
                  end
               end
            end
            XS_EXT: begin
               if (ext_ack_i) begin
                  ext_req_o    <= 1'b0;
                  xmov_ack_o   <= 1'b1;
                  xmov_rdata_o <= ext_rdata_i;
                  x_state      <= XS_DONE;
               end
            end
            XS_DONE: begin
               if (!xmov_req_i) begin
                  x_state <= XS_IDLE;                                               // Wait for release
               end
            end
            default: x_state <= XS_IDLE;
         endcase
      end
   end

   // Port pins change only for external cycles; on-chip moves leave them
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         muxed_addr_data_port_o <= 8'hFF;
         high_addr_port_o       <= 8'hFF;
      end else if (x_take && !hit_aux && !hit_nv) begin
         high_addr_port_o       <= eff_addr[15:8];
         muxed_addr_data_port_o <= eff_addr[7:0];
      end else if ((x_state == XS_EXT) && ext_ack_i) begin
         muxed_addr_data_port_o <= ext_we_o ? ext_wdata_o : ext_rdata_i;
      end
   end

   // Bus writes act at the edge that samples ack high
   assign wb_hit = wb_cyc_i && wb_stb_i && wb_ack_o;
   assign wb_wr  = wb_hit && wb_we_i && wb_sel_i[0];

   // Control and page select
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl     <= CTRL_RST;
         page_sel <= PAGE_RST[6:0];
         ev_mask  <= '0;
      end else if (wb_wr) begin
         if (wb_adr_i == OFS_CTRL) begin
            ctrl <= wb_dat_i[7:0];
         end
         if (wb_adr_i == OFS_PAGE) begin
            page_sel <= wb_dat_i[6:0];                                              // Busy bit is read only
         end
         if (wb_adr_i == OFS_MASK) begin
            ev_mask <= wb_dat_i[EV_W-1:0];
         end
      end
   end

   // Sticky events; a new event wins over a clear in the same cycle
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ev_stat <= '0;
      end else begin
         ev_stat <= (ev_stat & ~((wb_wr && (wb_adr_i == OFS_STAT)) ?
                                  wb_dat_i[EV_W-1:0] : EV_W'(0)))
                    | {nv_wr && !key_hit && !load_ok, prog_end};
      end
   end

   // Interrupt level from unmasked status
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(ev_stat & ev_mask);
      end
   end

   // Ack and read data, one wait state; unmapped offsets read zero
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         unique case (wb_adr_i)
            OFS_CTRL:  wb_dat_o <= {24'h0, ctrl};
            OFS_PAGE:  wb_dat_o <= {24'h0, nv_busy, page_sel};
            OFS_STAT:  wb_dat_o <= {30'h0, ev_stat};
            OFS_MASK:  wb_dat_o <= {30'h0, ev_mask};
            OFS_WPROT: wb_dat_o <= {31'h0, wprot};
            default:   wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end
endmodule

// File: xda_pkg.sv
// Constants shared by the external-data decoder: map, register layout, timing.
package xda_pkg;
   localparam int          CLK_MHZ         = 50;         // Core clock rate
   localparam int          LOAD_WINDOW_US  = 150;        // Byte-load window
   localparam int          LOAD_END_US     = 300;        // Silence that ends page load
   localparam int          PROG_TIME_US    = 2000;       // Internal programming time
   localparam int          LOAD_WINDOW_CYC = LOAD_WINDOW_US * CLK_MHZ; // Longest time, floor
   localparam int          LOAD_END_CYC    = LOAD_END_US * CLK_MHZ;    // Least time, exact
   localparam int          PROG_CYC        = PROG_TIME_US * CLK_MHZ;
   // Data-space map
   localparam logic [15:0] AUX_LAST        = 16'h01FF;   // Top of auxiliary RAM
   localparam logic [15:0] NV_FIRST        = 16'hFF80;   // Base of the nonvolatile array
   localparam logic [7:0]  PAGE_AUX0       = 8'h00;
   localparam logic [7:0]  PAGE_AUX1       = 8'h01;
   localparam logic [7:0]  PAGE_NV         = 8'h02;
   localparam int          NV_PAGE_BIT     = 6;          // Address bit choosing the nv page
   localparam int          BUSY_BIT        = 7;          // Busy flag in page select
   // Chip control bits
   localparam int          AUX_EN_BIT      = 4;
   localparam int          NV_EN_BIT       = 5;
   // Register byte offsets
   localparam logic [4:0]  OFS_CTRL        = 5'h00;      // Chip control
   localparam logic [4:0]  OFS_PAGE        = 5'h04;      // xdata_page_select_reg
   localparam logic [4:0]  OFS_STAT        = 5'h08;      // Sticky event status
   localparam logic [4:0]  OFS_MASK        = 5'h0C;      // Event mask
   localparam logic [4:0]  OFS_WPROT       = 5'h10;      // Protection state, read only
   // Status bits
   localparam int          EV_PROG_DONE    = 0;          // Programming cycle finished
   localparam int          EV_REFUSED      = 1;          // Nonvolatile write ignored
   localparam int          EV_W            = 2;
   // Reset values
   localparam logic [7:0]  CTRL_RST        = 8'h00;
   localparam logic [7:0]  PAGE_RST        = 8'h00;
   // Protection key: two unlock writes, then a command write
   localparam logic [6:0]  KEY_OFS_A       = 7'h55;
   localparam logic [6:0]  KEY_OFS_B       = 7'h2A;
   localparam logic [7:0]  KEY_DAT_A       = 8'hAA;
   localparam logic [7:0]  KEY_DAT_B       = 8'h55;
   localparam logic [7:0]  KEY_CMD_ON      = 8'hA0;
   localparam logic [7:0]  KEY_CMD_OFF     = 8'h80;
   typedef enum logic [1:0] {XS_IDLE, XS_EXT, XS_DONE} xda_xstate_t;
   typedef enum logic [1:0] {NS_IDLE, NS_LOAD, NS_PROG} xda_nvstate_t;
endpackage

// File: xda_xdata_decoder_asserts.sv
// Concurrent checks on the external-data decoder ports.
`timescale 1ns/1ps
module xda_xdata_decoder_chk
   import xda_pkg::*;
(
   input wire logic        mclk_i,
   input wire logic        reset_n_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [4:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic        wb_ack_o,
   input wire logic        xmov_req_i,
   input wire logic        xmov_ptr8_i,
   input wire logic [15:0] xmov_addr_i,
   input wire logic        xmov_ack_o,
   input wire logic [7:0]  xmov_rdata_o,
   input wire logic        ext_req_o,
   input wire logic        ext_we_o,
   input wire logic [15:0] ext_addr_o,
   input wire logic        ext_ack_i,
   input wire logic [7:0]  ext_rdata_i,
   input wire logic [7:0]  muxed_addr_data_port_o,
   input wire logic [7:0]  high_addr_port_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   logic       aux_en; // Mirror of the enables, kept from bus writes
   logic       nv_en;
   logic [6:0] pg;     // Mirror of the page field
   // Follow control writes so the decode can be predicted
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aux_en <= 1'b0;
         nv_en  <= 1'b0;
         pg     <= 7'h00;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]) begin
         if (wb_adr_i == OFS_CTRL) begin
            aux_en <= wb_dat_i[AUX_EN_BIT];
            nv_en  <= wb_dat_i[NV_EN_BIT];
         end
         if (wb_adr_i == OFS_PAGE) begin
            pg <= wb_dat_i[6:0];
         end
      end
   end
   wire logic aux_hit = aux_en && (xmov_ptr8_i ? (pg == PAGE_AUX0[6:0] || pg == PAGE_AUX1[6:0])
                                               : xmov_addr_i <= AUX_LAST);
   wire logic nv_hit  = nv_en && (xmov_ptr8_i ? pg == PAGE_NV[6:0] : xmov_addr_i >= NV_FIRST);
   property p_wb_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_wb_ack: assert property (p_wb_ack) else $error("bus ack late");
   property p_wb_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_wb_pulse: assert property (p_wb_pulse) else $error("bus ack too long");
   property p_aux; $rose(xmov_req_i) && aux_hit |=> xmov_ack_o && !ext_req_o; endproperty
   a_aux: assert property (p_aux) else $error("aux move not on chip");
   property p_aux_ports;
      $rose(xmov_req_i) && aux_hit |=>
         ($stable(muxed_addr_data_port_o) && $stable(high_addr_port_o))[*2];
   endproperty
   a_aux_ports: assert property (p_aux_ports) else $error("ports moved on aux move");
   property p_nv; $rose(xmov_req_i) && nv_hit |=> xmov_ack_o && !ext_req_o; endproperty
   a_nv: assert property (p_nv) else $error("nv move not on chip");
   property p_ext_go;
      $rose(xmov_req_i) && !xmov_ptr8_i && !aux_hit && !nv_hit |=>
         ext_req_o && ext_addr_o == $past(xmov_addr_i) && !xmov_ack_o;
   endproperty
   a_ext_go: assert property (p_ext_go) else $error("external cycle missing");
   property p_ext_hold;
      ext_req_o && !ext_ack_i |=> ext_req_o && $stable(ext_addr_o) && $stable(ext_we_o);
   endproperty
   a_ext_hold: assert property (p_ext_hold) else $error("external request moved");
   property p_ext_done; ext_req_o && ext_ack_i |=> !ext_req_o && xmov_ack_o; endproperty
   a_ext_done: assert property (p_ext_done) else $error("external end wrong");
   property p_ext_rd;
      ext_req_o && ext_ack_i && !ext_we_o |=> xmov_rdata_o == $past(ext_rdata_i);
   endproperty
   a_ext_rd: assert property (p_ext_rd) else $error("external read data wrong");
endmodule
bind xda_xdata_decoder xda_xdata_decoder_chk u_chk (.*);

// File: xda_ext_model.sv
// Behavioural external cycle engine facing the decoder.
`timescale 1ns/1ps
module xda_ext_model (
   input  wire logic        mclk_i,
   input  wire logic        reset_n_i,
   input  wire logic        slow_i,      // Stretch each cycle by five clocks
   input  wire logic        ext_req_i,
   input  wire logic        ext_we_i,
   input  wire logic [15:0] ext_addr_i,
   input  wire logic [7:0]  ext_wdata_i,
   output logic             ext_ack_o,
   output logic      [7:0]  ext_rdata_o
);
   logic [2:0] wait_cnt;   // Cycles spent before answering
   logic [7:0] last_wdata; // Last data written out, seen by the bench
   // Answer one request; the bus toggles when idle so no stale byte passes for data
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ext_ack_o   <= 1'b0;
         ext_rdata_o <= 8'h00;
         wait_cnt    <= 3'h0;
         last_wdata  <= 8'h00;
      end else begin
         ext_ack_o   <= 1'b0;
         ext_rdata_o <= ~ext_rdata_o;
         if (ext_req_i && !ext_ack_o) begin
            if (wait_cnt >= (slow_i ? 3'h5 : 3'h0)) begin
               ext_ack_o   <= 1'b1;
               wait_cnt    <= 3'h0;
               ext_rdata_o <= ext_addr_i[7:0] ^ ext_addr_i[15:8] ^ 8'h3C;
               if (ext_we_i) begin
                  last_wdata <= ext_wdata_i;
               end
            end else begin
               wait_cnt <= wait_cnt + 3'h1;
            end
         end
      end
   end
endmodule

// File: xda_testbench.sv
// Self-checking bench for the external-data decoder.
`timescale 1ns/1ps
module testbench;
   import xda_pkg::*;
   logic        mclk_i = 1'b0, reset_n_i = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
   logic [4:0]  adr = 5'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat;
   logic        req = 1'b0, mwe = 1'b0, p8 = 1'b0, xack, xrq, xwe, eack, slow = 1'b0;
   logic [15:0] maddr = 16'h0, xadr;
   logic [7:0]  mwd = 8'h00, mrd, xwd, erd, p0, p2, v;
   int          num_errors = 0, n_checks = 0;
   always #10 mclk_i = ~mclk_i;
   // Short counts keep page loading and programming quick
   xda_xdata_decoder #(.LOAD_WIN(20), .LOAD_END(40), .PROG_LEN(30)) u_xda_xdata_decoder (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .irq_o(irq), .xmov_req_i(req), .xmov_we_i(mwe), .xmov_ptr8_i(p8), .xmov_addr_i(maddr),
      .xmov_wdata_i(mwd), .xmov_ack_o(xack), .xmov_rdata_o(mrd), .ext_req_o(xrq),
      .ext_we_o(xwe), .ext_addr_o(xadr), .ext_wdata_o(xwd), .ext_ack_i(eack),
      .ext_rdata_i(erd), .muxed_addr_data_port_o(p0), .high_addr_port_o(p2));
   xda_ext_model u_xda_ext_model (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .slow_i(slow),
      .ext_req_i(xrq), .ext_we_i(xwe), .ext_addr_i(xadr), .ext_wdata_i(xwd),
      .ext_ack_o(eack), .ext_rdata_o(erd));
   // Byte the external engine returns for an address
   function automatic logic [7:0] ext_fn(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3C;
   endfunction
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Classic bus cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      @(posedge mclk_i);
      {cyc, stb, we, adr, sel, wdat} <= {1'b1, 1'b1, w, a, 4'hF, 24'h0, d};
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         $display("CHECK FAILED bus ack expected 1 seen 0");
         give_verdict();
      end
      q = rdat[7:0];
      {cyc, stb, we} <= 3'b000;
   endtask
   // Core data move, request held until ack
   task automatic mv(input logic w, input logic p, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q);
      int n;
      @(posedge mclk_i);
      {req, mwe, p8, maddr, mwd} <= {1'b1, w, p, a, d};
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (xack !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         $display("CHECK FAILED move ack expected 1 seen 0");
         give_verdict();
      end
      q = mrd;
      req <= 1'b0;
   endtask
   task automatic key(input logic [7:0] cmd);
      mv(1'b1, 1'b0, {9'h1FF, KEY_OFS_A}, KEY_DAT_A, v);
      mv(1'b1, 1'b0, {9'h1FF, KEY_OFS_B}, KEY_DAT_B, v);
      mv(1'b1, 1'b0, {9'h1FF, KEY_OFS_A}, cmd, v);
   endtask
   task automatic t_reset;
      wb(1'b0, OFS_CTRL, 8'h00, v);
      chk("ctrl", CTRL_RST, v);
      wb(1'b0, OFS_PAGE, 8'h00, v);
      chk("page", PAGE_RST, v);
      chk("p0 reset", 8'hFF, p0);
      chk("p2 reset", 8'hFF, p2);
      wb(1'b0, 5'h1C, 8'h00, v);
      chk("unmapped", 8'h00, v);
      $display("test reset done");
   endtask
   task automatic t_aux;
      mv(1'b0, 1'b0, 16'h0100, 8'h00, v);
      chk("aux off", ext_fn(16'h0100), v);
      slow <= 1'b1;
      mv(1'b1, 1'b0, 16'h1234, 8'h77, v);
      chk("ext data", 8'h77, u_xda_ext_model.last_wdata);
      chk("p2 ext", 8'h12, p2);
      slow <= 1'b0;
      wb(1'b1, OFS_CTRL, 8'h10, v);
      mv(1'b1, 1'b0, 16'h01FF, 8'h5A, v);
      mv(1'b1, 1'b0, 16'h0000, 8'hA5, v);
      mv(1'b0, 1'b0, 16'h01FF, 8'h00, v);
      chk("aux top", 8'h5A, v);
      chk("p0 hold", 8'h77, p0);
      chk("p2 hold", 8'h12, p2);
      wb(1'b1, OFS_PAGE, PAGE_AUX1, v);
      mv(1'b0, 1'b1, 16'h00FF, 8'h00, v);
      chk("ptr page 1", 8'h5A, v);
      wb(1'b1, OFS_PAGE, PAGE_AUX0, v);
      mv(1'b0, 1'b1, 16'h0000, 8'h00, v);
      chk("ptr page 0", 8'hA5, v);
      // A page outside the on-chip ones becomes the high byte of an external cycle
      wb(1'b1, OFS_PAGE, 8'h05, v);
      mv(1'b0, 1'b1, 16'h0033, 8'h00, v);
      chk("ptr page ext", ext_fn(16'h0533), v);
      mv(1'b0, 1'b0, 16'h0200, 8'h00, v);
      chk("above aux", ext_fn(16'h0200), v);
      $display("test aux done");
   endtask
   task automatic t_nv;
      int n;
      wb(1'b1, OFS_CTRL, 8'h30, v);
      wb(1'b1, OFS_MASK, 8'h01, v);
      // Descending offsets, each inside the load window, spanning past the end time
      for (int i = 0; i < 4; i++) begin
         mv(1'b1, 1'b0, 16'hFF80 + 16'(3 - i), 8'h10 + 8'(i), v);
         if (i < 3) repeat (12) @(posedge mclk_i);
      end
      mv(1'b1, 1'b0, 16'hFFC0, 8'h99, v);
      wb(1'b0, OFS_PAGE, 8'h00, v);
      chk("busy in load", 1'b0, v[BUSY_BIT]);
      wb(1'b0, OFS_STAT, 8'h00, v);
      chk("page mix", 1'b1, v[EV_REFUSED]);
      wb(1'b1, OFS_STAT, 8'h03, v);
      repeat (42) @(posedge mclk_i);
      wb(1'b0, OFS_PAGE, 8'h00, v);
      chk("busy prog", 1'b1, v[BUSY_BIT]);
      mv(1'b1, 1'b0, 16'hFF80, 8'hEE, v);
      wb(1'b0, OFS_STAT, 8'h00, v);
      chk("busy refuse", 1'b1, v[EV_REFUSED]);
      n = 0;
      do begin
         wb(1'b0, OFS_PAGE, 8'h00, v);
         n++;
      end while (v[BUSY_BIT] !== 1'b0 && n < 60);
      chk("busy end", 1'b0, v[BUSY_BIT]);
      if (n >= 60) give_verdict();
      chk("irq done", 1'b1, irq);
      wb(1'b1, OFS_PAGE, PAGE_NV, v);
      for (int i = 0; i < 4; i++) begin
         mv(1'b0, 1'b1, 16'h0080 + 16'(3 - i), 8'h00, v);
         chk("nv byte", 8'h10 + 8'(i), v);
      end
      wb(1'b1, OFS_STAT, 8'h03, v);
      wb(1'b0, OFS_STAT, 8'h00, v);
      chk("irq clear", 1'b0, irq);
      $display("test nv done");
   endtask
   task automatic t_prot;
      key(KEY_CMD_ON);
      wb(1'b0, OFS_WPROT, 8'h00, v);
      chk("prot on", 8'h01, v);
      mv(1'b1, 1'b0, 16'hFF90, 8'h44, v);
      wb(1'b0, OFS_STAT, 8'h00, v);
      chk("prot refuse", 1'b1, v[EV_REFUSED]);
      chk("irq masked", 1'b0, irq);
      key(KEY_CMD_OFF);
      wb(1'b0, OFS_WPROT, 8'h00, v);
      chk("prot off", 8'h00, v);
      $display("test protect done");
   endtask
   // Reset in mid-run, with the aux RAM enabled, must disable it again
   task automatic t_rerun;
      @(posedge mclk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      wb(1'b0, OFS_CTRL, 8'h00, v);
      chk("ctrl again", CTRL_RST, v);
      chk("p2 again", 8'hFF, p2);
      mv(1'b0, 1'b0, 16'h0100, 8'h00, v);
      chk("aux off again", ext_fn(16'h0100), v);
      $display("test reset again done");
   endtask
   initial begin
      repeat (8) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      t_reset();
      t_aux();
      t_nv();
      t_prot();
      t_rerun();
      give_verdict();
   end
endmodule
